// *** design/lmre_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lmre_map.svh"
module lmre_exec (
  input wire logic core_clk, // Instruction clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [13:0] instrWord, // Instruction word
  input wire logic instrValid, // Instruction word present
  output logic instrReady, // Block takes a valid word this cycle if the run bit is set
  input wire logic [14:0] topOfStack, // Return stack top
  output logic stackPop, // Pop pulse to the stack
  output logic [14:0] pc, // Program counter
  output logic [7:0] accumulator, // Accumulator
  output logic [4:0] bankSelector, // Bank selector
  output logic [6:0] pcHighLatch, // Program counter high latch
  output logic fileWe, // File write strobe
  output logic [15:0] fileAddr, // File write address
  output logic [7:0] fileData, // File write data
  output logic globalIntEnable, // Global interrupt enable
  output logic softwareResetIndicator, // Low after software reset
  output logic deviceResetReq, // Software reset pulse
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  lmre_pkg::lmre_op_e opKind;
  lmre_pkg::lmre_state_e state;
  lmre_pkg::lmre_state_e next_state;
  logic devRst;
  logic take;
  logic runEnable;
  logic [15:0] ptr [2];
  logic ptrSel;
  logic relMode;
  logic [15:0] selPtr;
  logic [15:0] targetAddr;
  logic [15:0] next_ptr;
  logic [6:0] fileField;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic regWrite;
  logic [31:0] next_rdata;
  logic rdHit;
  logic wrHit;

  // Software reset resets the core like the hardware reset; the bus interface and the reset indicator keep their state
  assign devRst = !rst_n || deviceResetReq; // RL12
  assign take = instrValid && instrReady && runEnable;
  assign fileField = instrWord[6:0];

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  always_comb begin
    opKind = lmre_pkg::LMRE_K_OTHER;
    if (instrWord == `LMRE_OP_NOP) begin
      opKind = lmre_pkg::LMRE_K_NOP; // RL16
    end else if (instrWord == `LMRE_OP_RESET) begin
      opKind = lmre_pkg::LMRE_K_RESET;
    end else if (instrWord == `LMRE_OP_RETFI) begin
      opKind = lmre_pkg::LMRE_K_RETFI;
    end else if ((instrWord & `LMRE_MSK_BANK) == `LMRE_PAT_BANK) begin
      opKind = lmre_pkg::LMRE_K_BANK;
    end else if ((instrWord & `LMRE_MSK_PAGE) == `LMRE_PAT_PAGE) begin
      opKind = lmre_pkg::LMRE_K_PAGE;
    end else if ((instrWord & `LMRE_MSK_ACC) == `LMRE_PAT_ACC) begin
      opKind = lmre_pkg::LMRE_K_ACC; // RL4
    end else if ((instrWord & `LMRE_MSK_STORE) == `LMRE_PAT_STORE) begin
      opKind = lmre_pkg::LMRE_K_STORE;
    end else if ((instrWord & `LMRE_MSK_INDM) == `LMRE_PAT_INDM) begin
      opKind = lmre_pkg::LMRE_K_INDM;
    end else if ((instrWord & `LMRE_MSK_INDK) == `LMRE_PAT_INDK) begin
      opKind = lmre_pkg::LMRE_K_INDK;
    end
  end

  // ------------------------------------------------------------
  // Pointer arithmetic
  // ------------------------------------------------------------
  assign relMode = (opKind == lmre_pkg::LMRE_K_INDK);
  assign ptrSel = relMode ? instrWord[`LMRE_SEL_BIT_K] :
    instrWord[`LMRE_SEL_BIT_M]; // RL8
  assign selPtr = ptr[ptrSel];

  lmre_ptr_calc u_ptr_calc (
    .ptrValue(selPtr),
    .modeField(instrWord[1:0]),
    .relMode(relMode),
    .offset(instrWord[5:0]),
    .targetAddr(targetAddr),
    .nextPtr(next_ptr)
  );

  // No status register is written by any path here
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ptr
      always_ff @(posedge core_clk) begin
        if (devRst) begin
          ptr[i] <= `LMRE_RST_PTR;
        end else if (take && (opKind == lmre_pkg::LMRE_K_INDM ||
            opKind == lmre_pkg::LMRE_K_INDK) && ptrSel == 1'(i)) begin
          ptr[i] <= next_ptr; // RL7 RL11
        end else if (regWrite && wStrb[0] && wStrb[1] &&
            awAddr == (i == 0 ? `LMRE_REG_PTR0 : `LMRE_REG_PTR1)) begin
          ptr[i] <= wData[15:0];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------
  always_comb begin
    next_state = lmre_pkg::LMRE_S_RUN;
    case (state)
      lmre_pkg::LMRE_S_RUN: begin
        if (take && opKind == lmre_pkg::LMRE_K_RETFI) begin
          next_state = lmre_pkg::LMRE_S_FLUSH; // RL15
        end else if (take && opKind == lmre_pkg::LMRE_K_RESET) begin
          next_state = lmre_pkg::LMRE_S_RESET;
        end
      end
      default: next_state = lmre_pkg::LMRE_S_RUN;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (devRst) begin
      state <= lmre_pkg::LMRE_S_RUN;
      instrReady <= 1'b0;
    end else begin
      state <= next_state;
      instrReady <= (next_state == lmre_pkg::LMRE_S_RUN); // RL15
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      deviceResetReq <= 1'b0;
    end else begin
      deviceResetReq <= take && opKind == lmre_pkg::LMRE_K_RESET; // RL12
    end
  end

  // ------------------------------------------------------------
  // Program counter and stack
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (devRst) begin
      pc <= `LMRE_RST_PC;
    end else if (take && opKind == lmre_pkg::LMRE_K_RETFI) begin
      pc <= topOfStack; // RL13
    end else if (take) begin
      pc <= pc + 15'h0001; // RL16
    end
  end

  always_ff @(posedge core_clk) begin
    if (devRst) begin
      stackPop <= 1'b0;
    end else begin
      stackPop <= take && opKind == lmre_pkg::LMRE_K_RETFI; // RL13
    end
  end

  // ------------------------------------------------------------
  // Literal loads
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (devRst) begin
      bankSelector <= `LMRE_RST_BANK;
    end else if (take && opKind == lmre_pkg::LMRE_K_BANK) begin
      bankSelector <= instrWord[4:0]; // RL1
    end
  end

  always_ff @(posedge core_clk) begin
    if (devRst) begin
      pcHighLatch <= `LMRE_RST_LATCH;
    end else if (take && opKind == lmre_pkg::LMRE_K_PAGE) begin
      pcHighLatch <= instrWord[6:0]; // RL2
    end
  end

  always_ff @(posedge core_clk) begin
    if (devRst) begin
      accumulator <= `LMRE_RST_ACC;
    end else if (take && opKind == lmre_pkg::LMRE_K_ACC) begin
      accumulator <= instrWord[7:0]; // RL3
    end
  end

  // ------------------------------------------------------------
  // Stores
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (devRst) begin
      fileWe <= 1'b0;
      fileAddr <= `LMRE_RST_PTR;
      fileData <= `LMRE_RST_ACC;
    end else begin
      fileWe <= 1'b0;
      if (take && opKind == lmre_pkg::LMRE_K_STORE) begin
        fileWe <= 1'b1; // RL5
        fileData <= accumulator; // RL5
        if (fileField == `LMRE_INDF0_ADDR ||
            fileField == `LMRE_INDF1_ADDR) begin
          fileAddr <= ptr[fileField[0]]; // RL9
        end else begin
          fileAddr <= {4'h0, bankSelector, fileField}; // RL5
        end
      end else if (take && (opKind == lmre_pkg::LMRE_K_INDM ||
          opKind == lmre_pkg::LMRE_K_INDK)) begin
        fileWe <= 1'b1;
        fileData <= accumulator;
        fileAddr <= targetAddr; // RL6 RL9
      end
    end
  end

  // ------------------------------------------------------------
  // Control bits
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (devRst) begin
      globalIntEnable <= `LMRE_RST_GIE;
    end else if (take && opKind == lmre_pkg::LMRE_K_RETFI) begin
      globalIntEnable <= 1'b1; // RL14
    end else if (regWrite && awAddr == `LMRE_REG_CTRL && wStrb[0]) begin
      globalIntEnable <= wData[`LMRE_GIE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (devRst) begin
      runEnable <= `LMRE_RST_RUN;
    end else if (regWrite && awAddr == `LMRE_REG_CTRL && wStrb[0]) begin
      runEnable <= wData[`LMRE_RUN_BIT];
    end
  end

  // Indicator survives the software reset it reports
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      softwareResetIndicator <= `LMRE_RST_RI;
    end else if (take && opKind == lmre_pkg::LMRE_K_RESET) begin
      softwareResetIndicator <= 1'b0; // RL12
    end else if (regWrite && awAddr == `LMRE_REG_CTRL && wStrb[1]) begin
      softwareResetIndicator <= wData[`LMRE_RI_BIT];
    end
  end

  // ------------------------------------------------------------
  // Register bus write
  // ------------------------------------------------------------
  assign regWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wrHit = awAddr == `LMRE_REG_CTRL || awAddr == `LMRE_REG_PTR0 ||
    awAddr == `LMRE_REG_PTR1;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LMRE_RESP_OKAY;
      awAddr <= `LMRE_REG_CTRL;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awAddr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (regWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `LMRE_RESP_OKAY : `LMRE_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Register bus read
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    rdHit = 1'b1;
    case (s_axi_araddr[7:0])
      `LMRE_REG_CTRL: begin
        next_rdata[`LMRE_RUN_BIT] = runEnable;
        next_rdata[`LMRE_GIE_BIT] = globalIntEnable;
        next_rdata[`LMRE_RI_BIT] = softwareResetIndicator;
      end
      `LMRE_REG_ACC: next_rdata[7:0] = accumulator;
      `LMRE_REG_LATCH: next_rdata[15:0] = {1'b0, pcHighLatch, 3'h0,
        bankSelector};
      `LMRE_REG_PTR0: next_rdata[15:0] = ptr[0];
      `LMRE_REG_PTR1: next_rdata[15:0] = ptr[1];
      `LMRE_REG_PC: next_rdata[14:0] = pc;
      default: rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LMRE_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rdHit ? `LMRE_RESP_OKAY : `LMRE_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  bank_load_a: assert property ( // RL1
    take && opKind == lmre_pkg::LMRE_K_BANK |=>
      bankSelector == $past(instrWord[4:0]))
    else $error("bank selector not loaded");
  page_load_a: assert property ( // RL2
    take && opKind == lmre_pkg::LMRE_K_PAGE |=>
      pcHighLatch == $past(instrWord[6:0]) && pc == $past(pc) + 15'h0001)
    else $error("pc high latch not loaded");
  acc_load_a: assert property ( // RL3
    take && opKind == lmre_pkg::LMRE_K_ACC |=>
      accumulator == $past(instrWord[7:0]) && !fileWe)
    else $error("accumulator not loaded");
  file_store_a: assert property ( // RL5
    take && opKind == lmre_pkg::LMRE_K_STORE && fileField > 7'h01 |=>
      fileWe && fileData == $past(accumulator) &&
      fileAddr == {4'h0, $past(bankSelector), $past(fileField)})
    else $error("file store wrong");
  indf_redirect_a: assert property ( // RL9
    take && opKind == lmre_pkg::LMRE_K_STORE &&
      fileField == `LMRE_INDF1_ADDR |=> fileWe && fileAddr == $past(ptr[1]))
    else $error("indirect port not redirected");
  rel_target_a: assert property ( // RL6
    take && opKind == lmre_pkg::LMRE_K_INDK |=>
      fileAddr == $past(selPtr) + {{10{$past(instrWord[5])}},
      $past(instrWord[5:0])} && ptr[$past(ptrSel)] == $past(selPtr))
    else $error("relative store wrong");
  preinc_ptr_a: assert property ( // RL7
    take && opKind == lmre_pkg::LMRE_K_INDM && instrWord[1:0] == 2'h0 |=>
      ptr[$past(ptrSel)] == $past(selPtr) + 16'h0001 &&
      fileAddr == $past(selPtr) + 16'h0001)
    else $error("pre-increment wrong");
  predec_wrap_a: assert property ( // RL10
    take && opKind == lmre_pkg::LMRE_K_INDM && instrWord[1:0] == 2'h1 &&
      selPtr == 16'h0000 |=> ptr[$past(ptrSel)] == 16'hFFFF &&
      fileAddr == 16'hFFFF)
    else $error("pointer did not wrap");
  soft_reset_a: assert property ( // RL12
    take && opKind == lmre_pkg::LMRE_K_RESET |=> deviceResetReq &&
      !softwareResetIndicator ##1 accumulator == `LMRE_RST_ACC &&
      pc == `LMRE_RST_PC && !instrReady)
    else $error("software reset wrong");
  return_int_a: assert property ( // RL13 RL14 RL15
    take && opKind == lmre_pkg::LMRE_K_RETFI |=> pc == $past(topOfStack) &&
      stackPop && globalIntEnable && !instrReady ##1 instrReady && !stackPop)
    else $error("return from interrupt wrong");
  nop_only_pc_a: assert property ( // RL16
    take && opKind == lmre_pkg::LMRE_K_NOP |=> pc == $past(pc) + 15'h0001 &&
      $stable(accumulator) && $stable(bankSelector) && !fileWe && instrReady)
    else $error("no operation changed state");
endmodule
`default_nettype wire

// *** design/lmre_map.svh ***
`ifndef LMRE_MAP_SVH
`define LMRE_MAP_SVH
// Function
// RL1 - Bank literal load puts its 5-bit operand into the bank selector.
// RL2 - Page latch literal load puts its 7-bit operand into the pc high latch.
// RL3 - Accumulator literal load puts its 8-bit operand into the accumulator.
// RL4 - Producer fills unused accumulator-load opcode bits with zero.
// RL5 - Accumulator-to-file store copies the accumulator to a file.
// RL6 - Indirect store target: pointer, pointer+1, pointer-1 or pointer+offset.
// RL7 - After indirect store pointer is +1, -1, or unchanged in relative mode.
// RL8 - Mode 0-3: pre-inc, pre-dec, post-inc, post-dec; a bit picks pointer.
// RL9 - Indirect data port has no storage; accesses use the pointer address.
// RL10 - Pointer is 16 bits and wraps modulo its full range.
// RL11 - Pointer updates and indirect store change no status flag.
// RL12 - Software reset resets the device and clears the reset indicator.
// RL13 - Return from interrupt pops the stack and loads top of stack into pc.
// RL14 - Return from interrupt sets global interrupt enable, bit 7.
// RL15 - Return from interrupt takes two instruction cycles.
// RL16 - No operation takes one cycle, advances pc, changes nothing else.

// ------------------------------------------------------------
// Instruction encodings
// ------------------------------------------------------------
`define LMRE_OP_NOP 14'h0000
`define LMRE_OP_RESET 14'h0001
`define LMRE_OP_RETFI 14'h0009
`define LMRE_MSK_BANK 14'h3FE0
`define LMRE_PAT_BANK 14'h0020
`define LMRE_MSK_PAGE 14'h3F80
`define LMRE_PAT_PAGE 14'h3180
`define LMRE_MSK_ACC 14'h3F00
`define LMRE_PAT_ACC 14'h3000
`define LMRE_MSK_STORE 14'h3F80
`define LMRE_PAT_STORE 14'h0080
`define LMRE_MSK_INDM 14'h3FF8
`define LMRE_PAT_INDM 14'h0018
`define LMRE_MSK_INDK 14'h3F80
`define LMRE_PAT_INDK 14'h3F80
`define LMRE_SEL_BIT_M 2
`define LMRE_SEL_BIT_K 6
`define LMRE_MM_PREINC 2'h0
`define LMRE_MM_PREDEC 2'h1
`define LMRE_MM_POSTINC 2'h2
`define LMRE_INDF0_ADDR 7'h00
`define LMRE_INDF1_ADDR 7'h01

// ------------------------------------------------------------
// Register map and fields
// ------------------------------------------------------------
`define LMRE_REG_CTRL 8'h00
`define LMRE_REG_ACC 8'h04
`define LMRE_REG_LATCH 8'h08
`define LMRE_REG_PTR0 8'h0C
`define LMRE_REG_PTR1 8'h10
`define LMRE_REG_PC 8'h14
`define LMRE_RUN_BIT 0
`define LMRE_GIE_BIT 7
`define LMRE_RI_BIT 8
`define LMRE_RESP_OKAY 2'h0
`define LMRE_RESP_SLVERR 2'h2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LMRE_RST_ACC 8'h00
`define LMRE_RST_BANK 5'h00
`define LMRE_RST_LATCH 7'h00
`define LMRE_RST_PTR 16'h0000
`define LMRE_RST_PC 15'h0000
`define LMRE_RST_RUN 1'h1
`define LMRE_RST_GIE 1'h0
`define LMRE_RST_RI 1'h1
`endif

// *** design/lmre_pkg.sv ***
package lmre_pkg;
  typedef enum {
    LMRE_K_OTHER,
    LMRE_K_NOP,
    LMRE_K_RESET,
    LMRE_K_RETFI,
    LMRE_K_BANK,
    LMRE_K_PAGE,
    LMRE_K_ACC,
    LMRE_K_STORE,
    LMRE_K_INDM,
    LMRE_K_INDK
  } lmre_op_e;

  typedef enum {
    LMRE_S_RUN,
    LMRE_S_FLUSH,
    LMRE_S_RESET
  } lmre_state_e;
endpackage

// *** design/lmre_ptr_calc.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lmre_map.svh"
module lmre_ptr_calc (
  input wire logic [15:0] ptrValue, // Selected pointer
  input wire logic [1:0] modeField, // Pointer mode field
  input wire logic relMode, // Signed offset form
  input wire logic [5:0] offset, // Signed offset
  output logic [15:0] targetAddr, // Effective address
  output logic [15:0] nextPtr // Pointer after the store
);
  logic [15:0] plusOne;
  logic [15:0] minusOne;
  logic [15:0] relAddr;

  // Sums are 16 bits so the pointer wraps modulo its range
  assign plusOne = ptrValue + 16'h0001; // RL10
  assign minusOne = ptrValue - 16'h0001; // RL10
  assign relAddr = ptrValue + {{10{offset[5]}}, offset}; // RL6

  always_comb begin
    targetAddr = ptrValue;
    nextPtr = ptrValue;
    if (relMode) begin
      targetAddr = relAddr; // RL6
      nextPtr = ptrValue; // RL7
    end else begin
      case (modeField) // RL8
        `LMRE_MM_PREINC: begin
          targetAddr = plusOne; // RL6
          nextPtr = plusOne; // RL7
        end
        `LMRE_MM_PREDEC: begin
          targetAddr = minusOne; // RL6
          nextPtr = minusOne; // RL7
        end
        `LMRE_MM_POSTINC: begin
          targetAddr = ptrValue;
          nextPtr = plusOne; // RL7
        end
        default: begin
          targetAddr = ptrValue;
          nextPtr = minusOne; // RL7
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** testbench/lmre_prog_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Program memory
// ------------------------------------------------------------
module lmre_prog_mem (
  input wire logic [14:0] pc, // Fetch address
  input wire logic enable, // Supply words
  output logic [13:0] instrWord, // Fetched word
  output logic instrValid // Word present
);
  logic [13:0] mem [0:63];

  task automatic put(input int a, input logic [13:0] w);
    mem[a] = w;
  endtask

  // Idle word is the inverse of the stored word, so a stale fetch differs from the word at pc
  assign instrWord = enable ? mem[pc[5:0]] : ~mem[pc[5:0]];
  assign instrValid = enable;
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lmre_map.svh"
module tb_top;
  logic core_clk, rst_n, enable, instrValid, instrReady, stackPop, fileWe;
  logic globalIntEnable, softwareResetIndicator, deviceResetReq;
  logic [13:0] instrWord;
  logic [14:0] topOfStack, pc;
  logic [7:0] accumulator, fileData;
  logic [4:0] bankSelector;
  logic [6:0] pcHighLatch;
  logic [15:0] fileAddr;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int errorCnt, nCompared, cycles, popCnt;
  logic [15:0] wrAddr [$];
  logic [7:0] wrData [$];
  logic [13:0] prog [0:12] = '{14'h30A5, 14'h003F, 14'h31FF, 14'h00C5,
    14'h0000, 14'h0018, 14'h001D, 14'h001A, 14'h001F, 14'h3FA0, 14'h3FDF,
    14'h0081, 14'h0009};
  logic [15:0] expAddr [0:7] = '{16'h0FC5, 16'h0000, 16'hFFFF, 16'h0000,
    16'hFFFF, 16'hFFE1, 16'h001D, 16'hFFFE};

  lmre_exec dut (.core_clk(core_clk), .rst_n(rst_n), .pc(pc),
    .instrWord(instrWord), .instrValid(instrValid), .instrReady(instrReady),
    .topOfStack(topOfStack), .stackPop(stackPop), .fileWe(fileWe),
    .accumulator(accumulator), .bankSelector(bankSelector),
    .pcHighLatch(pcHighLatch), .fileAddr(fileAddr), .fileData(fileData),
    .globalIntEnable(globalIntEnable), .deviceResetReq(deviceResetReq),
    .softwareResetIndicator(softwareResetIndicator),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  lmre_prog_mem pm (.pc(pc), .enable(enable), .instrWord(instrWord),
    .instrValid(instrValid));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic printVerdict();
    $display("compared %0d errors %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic axiWrite(input logic [31:0] a, d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(r));
    @(posedge core_clk);
  endtask

  task automatic axiRead(input logic [31:0] a, d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, d);
    check(32'(s_axi_rresp), 32'(r));
    @(posedge core_clk);
  endtask

  // Timeout, write capture and return monitor
  always @(posedge core_clk) begin
    cycles++;
    if (rst_n && fileWe === 1'b1) begin
      wrAddr.push_back(fileAddr);
      wrData.push_back(fileData);
    end
    if (rst_n && stackPop === 1'b1) begin
      popCnt++;
      check(32'(pc), 32'h14);
      check(32'(globalIntEnable), 32'h1);
      check(32'(instrReady), 32'h0);
    end
    if (deviceResetReq === 1'b1) check(32'(instrReady), 32'h0);
    if (cycles == 3000) begin
      errorCnt++;
      printVerdict();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    enable = 1'b0;
    topOfStack = 15'h0014;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_araddr = 32'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    for (int i = 0; i < 64; i++) begin
      pm.put(i, (i < 13) ? prog[i] : 14'h0000);
    end
    pm.put(20, `LMRE_OP_RESET);
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    axiWrite(32'h0C, 32'hFFFF, `LMRE_RESP_OKAY);
    axiWrite(32'h10, 32'h0, `LMRE_RESP_OKAY);
    axiWrite(32'h04, 32'h1, `LMRE_RESP_SLVERR);
    axiRead(32'h40, 32'h0, `LMRE_RESP_SLVERR);
    enable <= 1'b1;
    do @(posedge core_clk); while (pc !== 15'h0014);
    enable <= 1'b0;
    check(32'(accumulator), 32'hA5);
    check(32'(bankSelector), 32'h1F);
    check(32'(pcHighLatch), 32'h7F);
    axiRead(32'h08, 32'h7F1F, `LMRE_RESP_OKAY);
    axiRead(32'h0C, 32'h1, `LMRE_RESP_OKAY);
    axiRead(32'h10, 32'hFFFE, `LMRE_RESP_OKAY);
    axiRead(32'h00, 32'h181, `LMRE_RESP_OKAY);
    check(32'(popCnt), 32'h1);
    check(32'(wrAddr.size()), 32'h8);
    foreach (expAddr[i]) begin
      check(32'(wrAddr[i]), 32'(expAddr[i]));
      check(32'(wrData[i]), 32'hA5);
    end
    enable <= 1'b1;
    do @(posedge core_clk); while (deviceResetReq !== 1'b1);
    enable <= 1'b0;
    axiRead(32'h00, 32'h1, `LMRE_RESP_OKAY);
    axiRead(32'h0C, 32'h0, `LMRE_RESP_OKAY);
    check(32'(softwareResetIndicator), 32'h0);
    check(32'(accumulator), 32'h0);
    check(32'(pc), 32'h0);
    // Run bit low: offered words must not be taken
    axiWrite(32'h00, 32'h180, `LMRE_RESP_OKAY);
    enable <= 1'b1;
    repeat (3) @(posedge core_clk);
    enable <= 1'b0;
    check(32'(accumulator), 32'h0);
    check(32'(pc), 32'h0);
    axiRead(32'h00, 32'h180, `LMRE_RESP_OKAY);
    printVerdict();
  end
endmodule
`default_nettype wire
